// ---- core/gpb_bus_if.sv ----
// byte fifo and the instrument-side bus interface top
`timescale 1ns/10ps

// ------------------------------------------------------------
// synchronous fifo
// ------------------------------------------------------------
module gpb_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module gpb_bus_if #(
  parameter int FIFO_DEPTH = gpb_pkg::GPB_FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [4:0]        my_addr,
  input  wire logic [7:0]        dio_n_in,
  input  wire logic              atn_n_in,
  input  wire logic              ifc_n_in,
  input  wire logic              ren_n_in,
  input  wire logic              eoi_n_in,
  input  wire logic              dav_n_in,
  input  wire logic              nrfd_n_in,
  input  wire logic              ndac_n_in,
  output logic [7:0]             dio_n_out,
  output logic [7:0]             dio_n_oe,
  output logic                   eoi_n_out,
  output logic                   eoi_n_oe,
  output logic                   dav_n_out,
  output logic                   dav_n_oe,
  output logic                   nrfd_n_out,
  output logic                   nrfd_n_oe,
  output logic                   ndac_n_out,
  output logic                   ndac_n_oe,
  output logic                   srq_n_out,
  output logic                   srq_n_oe,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output gpb_pkg::gpb_byte_t     rx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire gpb_pkg::gpb_byte_t tx_data,
  input  wire logic              svc_request,
  input  wire logic [7:0]        status_byte,
  output logic                   listener,
  output logic                   talker,
  output logic                   remote,
  output logic                   lockout,
  output logic                   spoll_mode,
  output logic                   dev_clear
);
  // ------------------------------------------------------------
  // pin synchronisers, negative logic turned to true-high
  // ------------------------------------------------------------
  logic [gpb_pkg::GPB_PIN_W-1:0] pin_s1_reg;
  logic [gpb_pkg::GPB_PIN_W-1:0] pin_s2_reg;
  logic [gpb_pkg::GPB_PIN_W-1:0] pin_t;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
    end else begin
      pin_s1_reg <= {ndac_n_in, nrfd_n_in, dav_n_in, eoi_n_in, ren_n_in, ifc_n_in, atn_n_in, dio_n_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign pin_t = ~pin_s2_reg;

  logic       atn_t;
  logic       ifc_t;
  logic       ren_t;
  logic       eoi_t;
  logic       dav_t;
  logic       nrfd_t;
  logic       ndac_t;
  logic [7:0] dio_t;
  logic [6:0] cmd;

  assign dio_t  = pin_t[7:0];
  assign atn_t  = pin_t[gpb_pkg::GPB_P_ATN];
  assign ifc_t  = pin_t[gpb_pkg::GPB_P_IFC];
  assign ren_t  = pin_t[gpb_pkg::GPB_P_REN];
  assign eoi_t  = pin_t[gpb_pkg::GPB_P_EOI];
  assign dav_t  = pin_t[gpb_pkg::GPB_P_DAV];
  assign nrfd_t = pin_t[gpb_pkg::GPB_P_NRFD];
  assign ndac_t = pin_t[gpb_pkg::GPB_P_NDAC];
  assign cmd    = dio_t[6:0];

  // ------------------------------------------------------------
  // acceptor handshake
  // ------------------------------------------------------------
  typedef enum logic [1:0] {A_OFF, A_READY, A_HOLD, A_ACCEPT} gpb_acc_t;
  gpb_acc_t           acc_reg;
  gpb_pkg::gpb_byte_t acc_byte_reg;
  logic               acc_atn_reg;
  logic               acc_active;
  logic               take;
  logic               fifo_in_ready;
  logic               fifo_push;
  logic               ready_ok;
  logic               listener_reg;
  logic               talker_reg;

  // talker with attention false is the source, not an acceptor
  assign acc_active = atn_t || (listener_reg && !talker_reg);
  assign ready_ok   = atn_t || fifo_in_ready;
  assign take       = acc_active && acc_reg == A_READY && ready_ok && dav_t;
  assign fifo_push  = acc_reg == A_HOLD && !acc_atn_reg && listener_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_reg <= A_OFF;
    end else if (!acc_active) begin
      acc_reg <= A_OFF;
    end else begin
      unique case (acc_reg)
        A_OFF:    acc_reg <= dav_t ? A_OFF : A_READY;
        A_READY:  acc_reg <= take ? A_HOLD : A_READY;
        A_HOLD:   acc_reg <= (acc_atn_reg || !listener_reg || fifo_in_ready) ? A_ACCEPT : A_HOLD;
        A_ACCEPT: acc_reg <= dav_t ? A_ACCEPT : A_READY;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_byte_reg <= '0;
      acc_atn_reg  <= 1'b0;
    end else if (take) begin
      acc_byte_reg <= '{eoi: eoi_t, data: dio_t};
      acc_atn_reg  <= atn_t;
    end
  end

  gpb_fifo #(
    .W     ($bits(gpb_pkg::gpb_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (acc_byte_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ------------------------------------------------------------
  // command decode and interface state
  // ------------------------------------------------------------
  logic cmd_take;
  logic my_lag;
  logic my_tag;
  logic any_tag;
  logic remote_reg;
  logic lockout_reg;
  logic spoll_reg;
  logic dev_clear_reg;

  assign cmd_take = take && atn_t;
  assign my_lag   = cmd == {gpb_pkg::GPB_GRP_LAG, my_addr};
  assign my_tag   = cmd == {gpb_pkg::GPB_GRP_TAG, my_addr};
  // secondary group falls through every compare below
  assign any_tag  = cmd[gpb_pkg::GPB_GRP_HI:gpb_pkg::GPB_GRP_LO] == gpb_pkg::GPB_GRP_TAG;

  always_ff @(posedge ref_clk) begin
    if (reset || ifc_t) begin
      listener_reg <= 1'b0;
      talker_reg   <= 1'b0;
    end else if (cmd_take) begin
      listener_reg <= my_lag || (listener_reg && cmd != gpb_pkg::GPB_CMD_UNL);
      talker_reg   <= my_tag || (talker_reg && !any_tag && cmd != gpb_pkg::GPB_CMD_UNT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !ren_t) begin
      remote_reg  <= 1'b0;
      lockout_reg <= 1'b0;
    end else if (cmd_take) begin
      remote_reg  <= my_lag || (remote_reg && !(cmd == gpb_pkg::GPB_CMD_GTL && listener_reg));
      lockout_reg <= lockout_reg || cmd == gpb_pkg::GPB_CMD_LLO;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || ifc_t) begin
      spoll_reg <= 1'b0;
    end else if (cmd_take && cmd == gpb_pkg::GPB_CMD_SPE) begin
      spoll_reg <= 1'b1;
    end else if (cmd_take && cmd == gpb_pkg::GPB_CMD_SPD) begin
      spoll_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dev_clear_reg <= 1'b0;
    end else begin
      dev_clear_reg <= cmd_take && (cmd == gpb_pkg::GPB_CMD_DCL ||
                       (cmd == gpb_pkg::GPB_CMD_SDC && listener_reg));
    end
  end

  // ------------------------------------------------------------
  // source handshake
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_VALID, S_DONE} gpb_src_t;
  gpb_src_t           src_reg;
  gpb_pkg::gpb_byte_t src_byte_reg;
  logic               src_poll_reg;
  logic               src_active;
  logic               src_go;
  logic               spoll_sent;
  logic               srq_pend_reg;

  assign src_active = talker_reg && !atn_t;
  assign tx_ready   = src_active && src_reg == S_IDLE && !spoll_reg;
  assign src_go     = src_active && src_reg == S_IDLE && (spoll_reg || tx_valid);
  assign spoll_sent = src_reg == S_VALID && src_active && !ndac_t && src_poll_reg;

  always_ff @(posedge ref_clk) begin
    if (reset || !src_active) begin
      src_reg <= S_IDLE;
    end else begin
      unique case (src_reg)
        S_IDLE:  src_reg <= src_go ? S_WAIT : S_IDLE;
        S_WAIT:  src_reg <= (!nrfd_t && ndac_t) ? S_VALID : S_WAIT;
        S_VALID: src_reg <= ndac_t ? S_VALID : S_DONE;
        S_DONE:  src_reg <= (ndac_t || !nrfd_t) ? S_IDLE : S_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      src_byte_reg <= '0;
      src_poll_reg <= 1'b0;
    end else if (src_go) begin
      src_poll_reg <= spoll_reg;
      if (spoll_reg) begin
        src_byte_reg.eoi  <= 1'b0;
        src_byte_reg.data <= status_byte;
        src_byte_reg.data[gpb_pkg::GPB_RQS_BIT] <= srq_pend_reg;
      end else begin
        src_byte_reg <= tx_data;
      end
    end
  end

  // request is sticky; a new request wins over the poll clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      srq_pend_reg <= 1'b0;
    end else begin
      srq_pend_reg <= svc_request || (srq_pend_reg && !spoll_sent);
    end
  end

  // ------------------------------------------------------------
  // pin drivers: control lines open-drain, enable high pulls them true; dio enables all eight and drives ~data
  // ------------------------------------------------------------
  logic src_drive;
  assign src_drive  = src_active && src_reg != S_IDLE;
  assign dio_n_out  = ~src_byte_reg.data;
  assign dio_n_oe   = src_drive ? 8'hff : 8'h00;
  assign eoi_n_out  = 1'b0;
  assign eoi_n_oe   = src_drive && src_byte_reg.eoi;
  assign dav_n_out  = 1'b0;
  assign dav_n_oe   = src_active && src_reg == S_VALID;
  assign nrfd_n_out = 1'b0;
  assign nrfd_n_oe  = acc_active && (acc_reg != A_READY || !ready_ok);
  assign ndac_n_out = 1'b0;
  assign ndac_n_oe  = acc_active && acc_reg != A_ACCEPT;
  assign srq_n_out  = 1'b0;
  assign srq_n_oe   = srq_pend_reg;

  assign listener   = listener_reg;
  assign talker     = talker_reg;
  assign remote     = remote_reg;
  assign lockout    = lockout_reg;
  assign spoll_mode = spoll_reg;
  assign dev_clear  = dev_clear_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_DAV_AFTER_READY: assert property ($rose(dav_n_oe) |-> $past(!nrfd_t && ndac_t))
    else $error("data valid asserted before acceptors ready");
  AST_DAV_SOURCE_ONLY: assert property (dav_n_oe |-> talker_reg && !atn_t && !nrfd_n_oe)
    else $error("data valid driven while not source");
  AST_IDLE_RELEASED: assert property (!talker_reg && !acc_active |->
                                      !dav_n_oe && !nrfd_n_oe && !ndac_n_oe && dio_n_oe == 8'h00)
    else $error("idle device holds a bus line");
  AST_IFC_CLEARS: assert property (ifc_t |=> !listener_reg && !talker_reg && !spoll_reg)
    else $error("interface clear left addressing");
  AST_UNL_CLEARS: assert property (cmd_take && cmd == gpb_pkg::GPB_CMD_UNL && !ifc_t |=> !listener_reg)
    else $error("unlisten did not clear listener");
  AST_LLO_SETS: assert property (cmd_take && cmd == gpb_pkg::GPB_CMD_LLO && ren_t |=> lockout_reg)
    else $error("local lockout not taken");
  AST_PUSH_DATA_ONLY: assert property (take && atn_t |=> !fifo_push)
    else $error("command byte pushed as data");
  AST_NDAC_AFTER_TAKE: assert property (take |=> ndac_n_oe && nrfd_n_oe)
    else $error("acceptor released lines before byte held");
  AST_SRQ_HOLDS: assert property (srq_pend_reg && !spoll_sent |=> srq_n_oe)
    else $error("service request dropped before poll");
  AST_SDC_NEEDS_LAG: assert property (cmd_take && cmd == gpb_pkg::GPB_CMD_SDC && !listener_reg
                                      && cmd != gpb_pkg::GPB_CMD_DCL |=> !dev_clear_reg)
    else $error("selective clear acted while unaddressed");

  COV_DATA_RX: cover property (fifo_push && acc_byte_reg.eoi);
  COV_POLL_TX: cover property (spoll_sent);
  COV_TX_BYTE: cover property (tx_valid && tx_ready ##[1:50] src_reg == S_DONE);
endmodule

// ---- core/gpb_pkg.sv ----
// shared constants and types of the instrument-side bus interface
package gpb_pkg;
  // ------------------------------------------------------------
  // multiline command codes, seven bits, parity bit ignored
  // ------------------------------------------------------------
  localparam logic [6:0] GPB_CMD_GTL  = 7'h01;
  localparam logic [6:0] GPB_CMD_SDC  = 7'h04;
  localparam logic [6:0] GPB_CMD_LLO  = 7'h11;
  localparam logic [6:0] GPB_CMD_DCL  = 7'h14;
  localparam logic [6:0] GPB_CMD_SPE  = 7'h18;
  localparam logic [6:0] GPB_CMD_SPD  = 7'h19;
  localparam logic [6:0] GPB_CMD_UNL  = 7'h3f;
  localparam logic [6:0] GPB_CMD_UNT  = 7'h5f;
  localparam logic [1:0] GPB_GRP_LAG  = 2'h1;
  localparam logic [1:0] GPB_GRP_TAG  = 2'h2;
  localparam int         GPB_GRP_HI   = 6;
  localparam int         GPB_GRP_LO   = 5;
  localparam int         GPB_RQS_BIT  = 6;
  // ------------------------------------------------------------
  // pin vector layout after synchronisation
  // ------------------------------------------------------------
  localparam int         GPB_PIN_W    = 15;
  localparam int         GPB_P_ATN    = 8;
  localparam int         GPB_P_IFC    = 9;
  localparam int         GPB_P_REN    = 10;
  localparam int         GPB_P_EOI    = 11;
  localparam int         GPB_P_DAV    = 12;
  localparam int         GPB_P_NRFD   = 13;
  localparam int         GPB_P_NDAC   = 14;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int         GPB_CLK_MHZ  = 125;
  localparam int         GPB_SETTLE_NS = 100;
  localparam int         GPB_SETTLE_CYC = (GPB_SETTLE_NS * GPB_CLK_MHZ + 999) / 1000;
  localparam int         GPB_FIFO_DEPTH = 8;
  // ------------------------------------------------------------
  // one bus byte with its end mark
  // ------------------------------------------------------------
  typedef struct packed {
    logic       eoi;
    logic [7:0] data;
  } gpb_byte_t;
endpackage

// ---- bench/gpb_ctrl_model.sv ----
// controller-side model of the instrument bus
`timescale 1ns/10ps

module gpb_ctrl_model (
  input  wire logic [7:0] dio_w,
  input  wire logic       ref_clk,
  input  wire logic       eoi_w,
  input  wire logic       dav_w,
  input  wire logic       nrfd_w,
  input  wire logic       ndac_w,
  output logic [7:0]      c_dio_n,
  output logic            c_atn_n,
  output logic            c_ifc_n,
  output logic            c_ren_n,
  output logic            c_eoi_n,
  output logic            c_dav_n,
  output logic            c_nrfd_n,
  output logic            c_ndac_n
);
  localparam int LIM = 200;

  // released lines float high through the pull-ups
  initial begin
    {c_dio_n, c_atn_n, c_ifc_n, c_ren_n, c_eoi_n} = 12'hfff;
    {c_dav_n, c_nrfd_n, c_ndac_n}                 = 3'h7;
  end

  task automatic lines(input logic atn, input logic ifc, input logic ren);
    @(negedge ref_clk);
    c_atn_n = ~atn;
    c_ifc_n = ~ifc;
    c_ren_n = ~ren;
  endtask

  task automatic send(input logic atn, input logic [7:0] b, input logic eoi, output logic ok);
    int n;
    lines(atn, 1'b0, ~c_ren_n);
    c_dio_n = ~b;
    c_eoi_n = ~eoi;
    if (atn) repeat (gpb_pkg::GPB_SETTLE_CYC) @(negedge ref_clk);
    n = 0;
    while (!(nrfd_w && !ndac_w) && n < LIM) begin
      @(negedge ref_clk);
      n++;
    end
    ok = (n < LIM);
    if (ok) begin
      c_dav_n = 1'b0;
      n = 0;
      while (!ndac_w && n < LIM) begin
        @(negedge ref_clk);
        n++;
      end
      ok = (n < LIM);
    end
    c_dav_n = 1'b1;
    c_dio_n = 8'hff;
    c_eoi_n = 1'b1;
  endtask

  // acceptor side, dly stretches the accept time
  task automatic receive(input int dly, output logic [8:0] r, output logic ok);
    int n;
    @(negedge ref_clk);
    c_nrfd_n = 1'b1;
    c_ndac_n = 1'b0;
    n = 0;
    while (dav_w && n < LIM) begin
      @(negedge ref_clk);
      n++;
    end
    ok = (n < LIM);
    r = {~eoi_w, ~dio_w};
    c_nrfd_n = 1'b0;
    repeat (dly) @(negedge ref_clk);
    c_ndac_n = 1'b1;
    while (!dav_w && n < LIM) begin
      @(negedge ref_clk);
      n++;
    end
    c_ndac_n = 1'b0;
    c_nrfd_n = 1'b1;
  endtask

  task automatic idle();
    @(negedge ref_clk);
    c_ndac_n = 1'b1;
    c_nrfd_n = 1'b1;
  endtask
endmodule

// ---- bench/gpb_bus_if_test.sv ----
// self-checking bench of the instrument-side bus interface
`timescale 1ns/10ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end

module gpb_bus_if_test;
  typedef struct packed {
    logic [7:0] b;
    logic [4:0] st;
    logic [3:0] clr;
  } gpb_row_t;

  logic ref_clk, reset, rx_ready, tx_valid, svc_request, ok;
  logic rx_valid, tx_ready, listener, talker, remote, lockout, spoll_mode, dev_clear;
  logic [7:0] dio_w, dio_n_out, dio_n_oe, c_dio_n;
  logic eoi_n_out, eoi_n_oe, dav_n_out, dav_n_oe, nrfd_n_out, nrfd_n_oe;
  logic ndac_n_out, ndac_n_oe, srq_n_out, srq_n_oe;
  logic c_atn_n, c_ifc_n, c_ren_n, c_eoi_n, c_dav_n, c_nrfd_n, c_ndac_n;
  logic eoi_w, dav_w, nrfd_w, ndac_w, srq_w;
  logic [7:0] status_byte;
  logic [8:0] r;
  logic [4:0] st, my_addr;
  logic [3:0] clr_count;
  gpb_pkg::gpb_byte_t rx_data, tx_data;
  gpb_pkg::gpb_byte_t rxq[$];
  int err_count, num_checks, cyc;

  gpb_row_t   rows [18] = '{'{8'h2a, 5'h14, 4'h0}, '{8'h3f, 5'h04, 4'h0}, '{8'h01, 5'h04, 4'h0},
    '{8'h04, 5'h04, 4'h0}, '{8'h2a, 5'h14, 4'h0}, '{8'h6a, 5'h14, 4'h0}, '{8'h11, 5'h16, 4'h0},
    '{8'h4a, 5'h1e, 4'h0}, '{8'h45, 5'h16, 4'h0}, '{8'h4a, 5'h1e, 4'h0}, '{8'h5f, 5'h16, 4'h0},
    '{8'h18, 5'h17, 4'h0}, '{8'h19, 5'h16, 4'h0}, '{8'h14, 5'h16, 4'h1}, '{8'h04, 5'h16, 4'h2},
    '{8'h01, 5'h12, 4'h2}, '{8'h3f, 5'h02, 4'h2}, '{8'h14, 5'h02, 4'h3}};
  logic [7:0] dat [8]  = '{8'h3f, 8'h5f, 8'h14, 8'h04, 8'h01, 8'h4a, 8'h00, 8'hff};
  logic [8:0] txd [3]  = '{9'h0a5, 9'h03c, 9'h1c3};

  // ------------------------------------------------------------
  // wired-and bus
  // ------------------------------------------------------------
  assign dio_w  = c_dio_n & (dio_n_out | ~dio_n_oe);
  assign eoi_w  = c_eoi_n & (eoi_n_out | ~eoi_n_oe);
  assign dav_w  = c_dav_n & (dav_n_out | ~dav_n_oe);
  assign nrfd_w = c_nrfd_n & (nrfd_n_out | ~nrfd_n_oe);
  assign ndac_w = c_ndac_n & (ndac_n_out | ~ndac_n_oe);
  assign srq_w  = srq_n_out | ~srq_n_oe;
  assign st     = {listener, talker, remote, lockout, spoll_mode};

  gpb_ctrl_model ctrl (.ref_clk(ref_clk), .dio_w(dio_w), .eoi_w(eoi_w), .dav_w(dav_w), .nrfd_w(nrfd_w),
    .ndac_w(ndac_w), .c_dio_n(c_dio_n), .c_atn_n(c_atn_n), .c_ifc_n(c_ifc_n), .c_ren_n(c_ren_n),
    .c_eoi_n(c_eoi_n), .c_dav_n(c_dav_n), .c_nrfd_n(c_nrfd_n), .c_ndac_n(c_ndac_n));

  gpb_bus_if #(.FIFO_DEPTH(gpb_pkg::GPB_FIFO_DEPTH)) DUT (.ref_clk(ref_clk), .reset(reset),
    .my_addr(my_addr), .dio_n_in(dio_w), .atn_n_in(c_atn_n), .ifc_n_in(c_ifc_n), .ren_n_in(c_ren_n),
    .eoi_n_in(eoi_w), .dav_n_in(dav_w), .nrfd_n_in(nrfd_w), .ndac_n_in(ndac_w), .dio_n_out(dio_n_out),
    .dio_n_oe(dio_n_oe), .eoi_n_out(eoi_n_out), .eoi_n_oe(eoi_n_oe), .dav_n_out(dav_n_out),
    .dav_n_oe(dav_n_oe), .nrfd_n_out(nrfd_n_out), .nrfd_n_oe(nrfd_n_oe), .ndac_n_out(ndac_n_out),
    .ndac_n_oe(ndac_n_oe), .srq_n_out(srq_n_out), .srq_n_oe(srq_n_oe), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .svc_request(svc_request), .status_byte(status_byte), .listener(listener), .talker(talker),
    .remote(remote), .lockout(lockout), .spoll_mode(spoll_mode), .dev_clear(dev_clear));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (dev_clear === 1'b1) clr_count <= clr_count + 4'h1;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic tx_put(input logic [8:0] v);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (tx_ready !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    tx_valid = 1'b1;
    tx_data  = v;
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {reset, rx_ready, tx_valid, svc_request} = 4'h8;
    {tx_data, clr_count} = 13'h0;
    my_addr = 5'h0a;
    status_byte = 8'h81;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    `CHK({dio_n_oe, eoi_n_oe, dav_n_oe, nrfd_n_oe, ndac_n_oe, srq_n_oe}, 13'h0)
    `CHK({st, rx_valid, tx_ready}, 7'h0)
    $display("test reset done");
    ctrl.lines(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 18; i++) begin
      ctrl.send(1'b1, rows[i].b, 1'b0, ok);
      `CHK(ok, 1'b1)
      `CHK(st, rows[i].st)
      `CHK(clr_count, rows[i].clr)
    end
    $display("test command table done");
    ctrl.lines(1'b0, 1'b0, 1'b0);
    repeat (8) @(negedge ref_clk);
    `CHK({nrfd_n_oe, ndac_n_oe, dav_n_oe, dio_n_oe}, 11'h0)
    `CHK({remote, lockout}, 2'h0)
    ctrl.lines(1'b0, 1'b0, 1'b1);
    $display("test idle release done");
    rx_ready = 1'b0;
    ctrl.send(1'b1, 8'h2a, 1'b0, ok);
    for (int i = 0; i < 8; i++) begin
      ctrl.send(1'b0, dat[i], i == 7, ok);
      `CHK(ok, 1'b1)
    end
    ctrl.send(1'b0, 8'h55, 1'b0, ok);
    `CHK(ok, 1'b0)
    rx_ready = 1'b1;
    repeat (20) @(negedge ref_clk);
    `CHK(rxq.size(), 8)
    for (int i = 0; i < 8; i++) `CHK(rxq[i], {i == 7, dat[i]})
    `CHK(st, 5'h14)
    `CHK(clr_count, 4'h3)
    $display("test listen fill done");
    ctrl.send(1'b1, 8'h4a, 1'b0, ok);
    ctrl.lines(1'b0, 1'b0, 1'b1);
    fork
      for (int i = 0; i < 3; i++) tx_put(txd[i]);
      for (int i = 0; i < 3; i++) begin
        ctrl.receive((i == 1) ? 20 : 0, r, ok);
        `CHK({ok, r}, {1'b1, txd[i]})
      end
    join
    ctrl.idle();
    $display("test talk done");
    svc_request = 1'b1;
    @(negedge ref_clk);
    svc_request = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(srq_w, 1'b0)
    repeat (30) @(negedge ref_clk);
    `CHK(srq_w, 1'b0)
    ctrl.send(1'b1, 8'h18, 1'b0, ok);
    ctrl.lines(1'b0, 1'b0, 1'b1);
    ctrl.receive(0, r, ok);
    ctrl.idle();
    `CHK(r[7:0], 8'hc1)
    repeat (4) @(negedge ref_clk);
    `CHK(srq_w, 1'b1)
    ctrl.send(1'b1, 8'h19, 1'b0, ok);
    `CHK(spoll_mode, 1'b0)
    $display("test serial poll done");
    ctrl.lines(1'b1, 1'b1, 1'b1);
    repeat (4) @(negedge ref_clk);
    ctrl.lines(1'b1, 1'b0, 1'b1);
    `CHK({listener, talker}, 2'h0)
    $display("test interface clear done");
    my_addr = 5'h00;
    ctrl.send(1'b1, 8'h2a, 1'b0, ok);
    `CHK(listener, 1'b0)
    ctrl.send(1'b1, 8'h20, 1'b0, ok);
    `CHK(listener, 1'b1)
    $display("test address change done");
    report_and_stop();
  end
endmodule
